/* File: verilog/ast_pkg.sv */
// package for the single-edge nibble angle transmitter
// assumes one 200 MHz clock and nonvolatile words presented as static inputs
package ast_pkg;
    // ======================================================================
    // configuration word map
    localparam logic [11:0] AST_TRIM_ADDR    = 12'h306;
    localparam int          AST_TRIM_MSB     = 12;
    localparam int          AST_TRIM_LSB     = 0;
    localparam logic [12:0] AST_TRIM_RESET   = 13'h0000;
    // ======================================================================
    // timing
    localparam int          AST_CLK_PS       = 5000;
    localparam int          AST_TICK_MIN_PS  = 500000;
    localparam int          AST_TICK_MAX_PS  = 7900000;
    localparam int          AST_TICK_MIN_CYC = (AST_TICK_MIN_PS + AST_CLK_PS - 1) / AST_CLK_PS;
    localparam int          AST_TICK_MAX_CYC = AST_TICK_MAX_PS / AST_CLK_PS;
    localparam logic [4:0]  AST_LOW_TICKS    = 5'h05;
    localparam logic [4:0]  AST_HIGH_BASE    = 5'h07;
    localparam logic [5:0]  AST_SYNC_TICKS   = 6'h38;
    localparam logic [5:0]  AST_PAUSE_TICKS  = 6'h0c;
    localparam logic [11:0] AST_FULL_SCALE   = 12'hfff;
    localparam logic [3:0]  AST_CRC_SEED     = 4'h5;
    localparam int          AST_DATA_NIBS    = 3;
    // ======================================================================
    // modes
    typedef enum logic [1:0]
    {
        AST_MODE_FREE,
        AST_MODE_TRIG,
        AST_MODE_ADDR,
        AST_MODE_POLL
    } ast_mode_e;
    typedef struct packed
    {
        ast_mode_e  mode;
        logic [10:0] tick_cyc;
        logic       pause_en;
        logic       serial_en;
        logic [3:0] addr;
    } ast_cfg_s;
endpackage

/* File: verilog/ast_sent_tx.sv */
// single-edge nibble angle transmitter, device side
// assumes configuration words are stable and inputs synchronous to clk
// What this block does
// R1: angle code spans the full-scale range zero to 4095.
// R2: frame settings come from the nonvolatile configuration inputs.
// R3: supports free-streaming, triggered and shared-line transmission modes.
// R4: free-streaming tick programmable from 0.5 to 7.9 microseconds.
// R5: triggered mode sends one frame per request only.
// R6: shared line answers when addressed or when its poll turn comes.
// R7: each nibble is a low interval then a high interval.
// R8: low interval is always exactly five ticks.
// R9: high interval is seven plus nibble value ticks.
// R10: nibble lasts twelve to twenty-seven ticks in total.
// R11: all intervals timed in ticks of the configured tick period.
// R12: order is sync, status, data nibbles, crc, optional pause.
// R13: status nibble carries status bits and optional serial bit.
// R14: data nibbles carry the angle ahead of the crc.
// R15: optional pause pulse follows the crc between frames.
// R16: output angle is linearized angle minus zero offset.
// R17: zero offset is bits 12:0 of configuration word 0x306.
// R18: offset subtraction happens after linearization only.
// R19: programming mode stops output at once, dropping the frame.
// R20: sync pulse lasts fifty-six ticks.
// R21: crc is four-bit standard crc over status and data nibbles.
`timescale 1ns/100ps
`default_nettype none
module ast_sent_tx
#(
    parameter int ANGLE_W = 13
)
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire ast_pkg::ast_cfg_s cfg,
    input  wire logic [11:0]       cfg_addr,
    input  wire logic [15:0]       cfg_word,
    input  wire logic              cfg_load,
    input  wire logic [ANGLE_W-1:0] lin_angle,
    input  wire logic [1:0]        status_bits,
    input  wire logic              serial_bit,
    input  wire logic              trigger,
    input  wire logic              addr_hit,
    input  wire logic              poll_turn,
    input  wire logic              prog_mode,
    output logic                   line_out,
    output logic                   frame_busy,
    output logic [11:0]            angle_out
);
    import ast_pkg::*;

    typedef enum logic [2:0]
    {
        AST_IDLE,
        AST_SYNC,
        AST_NIB,
        AST_PAUSE
    } ast_state_e;

    ast_state_e  state_reg;
    logic [12:0] trim_reg;
    logic [10:0] tick_cnt_reg;
    logic        tick;
    logic [5:0]  seg_cnt_reg;
    logic [2:0]  nib_idx_reg;
    logic [3:0]  nib_val [0:5];
    logic [3:0]  crc_reg;
    logic [11:0] ang_reg;
    logic [3:0]  stat_reg;
    logic [10:0] tick_len;
    logic        start;
    logic [5:0]  nib_len;
    logic [12:0] diff;

    // ======================================================================
    // zero offset capture and angle path
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            trim_reg <= AST_TRIM_RESET;
        else if (cfg_load && cfg_addr == AST_TRIM_ADDR) // R2 R17
            trim_reg <= cfg_word[AST_TRIM_MSB:AST_TRIM_LSB]; // R17
    end

    // subtract after linearization, wrap into full scale
    assign diff = 13'(lin_angle - trim_reg); // R16 R18
    assign angle_out = ang_reg;

    // ======================================================================
    // tick generator
    always_comb
    begin
        tick_len = cfg.tick_cyc; // R4 R11
        if (tick_len < 11'(AST_TICK_MIN_CYC))
            tick_len = 11'(AST_TICK_MIN_CYC);
        if (tick_len > 11'(AST_TICK_MAX_CYC))
            tick_len = 11'(AST_TICK_MAX_CYC);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            tick_cnt_reg <= 11'h000;
        else if (state_reg == AST_IDLE || tick)
            tick_cnt_reg <= 11'h000;
        else
            tick_cnt_reg <= tick_cnt_reg + 11'h001;
    end
    assign tick = (state_reg != AST_IDLE) && (tick_cnt_reg == tick_len - 11'h001); // R11

    // ======================================================================
    // frame start per mode
    always_comb
    begin
        case (cfg.mode) // R3
            AST_MODE_FREE: start = 1'b1;
            AST_MODE_TRIG: start = trigger; // R5
            AST_MODE_ADDR: start = addr_hit; // R6
            AST_MODE_POLL: start = poll_turn; // R6
            default:       start = 1'b0;
        endcase
    end

    // ======================================================================
    // nibble contents and crc
    always_comb
    begin
        nib_val[0] = stat_reg; // R13
        nib_val[1] = ang_reg[11:8]; // R14
        nib_val[2] = ang_reg[7:4];
        nib_val[3] = ang_reg[3:0];
        nib_val[4] = crc_reg; // R21
        nib_val[5] = 4'h0;
    end

    function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] d);
        logic [3:0] r;
        logic       fb;
        r = c;
        for (int i = 3; i >= 0; i--)
        begin
            fb = r[3];
            r  = {r[2:0], 1'b0} ^ (fb ? 4'hd : 4'h0);
        end
        return r ^ d;
    endfunction

    function automatic logic [3:0] crc_frame(input logic [3:0] s, input logic [11:0] a);
        logic [3:0] c;
        c = AST_CRC_SEED;
        c = crc_step(c, s);
        c = crc_step(c, a[11:8]);
        c = crc_step(c, a[7:4]);
        c = crc_step(c, a[3:0]);
        c = crc_step(c, 4'h0);
        return c;
    endfunction

    assign nib_len = {2'b00, nib_val[nib_idx_reg]} + {1'b0, AST_LOW_TICKS} + {1'b0, AST_HIGH_BASE}; // R10

    // ======================================================================
    // frame sequencer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg   <= AST_IDLE;
            seg_cnt_reg <= 6'h00;
            nib_idx_reg <= 3'h0;
            ang_reg     <= 12'h000;
            stat_reg    <= 4'h0;
            crc_reg     <= 4'h0;
        end
        else if (prog_mode) // R19
        begin
            state_reg   <= AST_IDLE;
            seg_cnt_reg <= 6'h00;
            nib_idx_reg <= 3'h0;
        end
        else
        begin
            case (state_reg)
                AST_IDLE:
                    if (start)
                    begin
                        ang_reg     <= diff[11:0] & AST_FULL_SCALE; // R1
                        stat_reg    <= {cfg.serial_en & serial_bit, 1'b0, status_bits}; // R13
                        crc_reg     <= crc_frame({cfg.serial_en & serial_bit, 1'b0, status_bits},
                                                 diff[11:0]); // R21
                        seg_cnt_reg <= 6'h00;
                        state_reg   <= AST_SYNC; // R12
                    end
                AST_SYNC:
                    if (tick)
                    begin
                        if (seg_cnt_reg == AST_SYNC_TICKS - 6'h01) // R20
                        begin
                            seg_cnt_reg <= 6'h00;
                            nib_idx_reg <= 3'h0;
                            state_reg   <= AST_NIB;
                        end
                        else
                            seg_cnt_reg <= seg_cnt_reg + 6'h01;
                    end
                AST_NIB:
                    if (tick)
                    begin
                        if (seg_cnt_reg == nib_len - 6'h01) // R9 R10
                        begin
                            seg_cnt_reg <= 6'h00;
                            if (nib_idx_reg == 3'(AST_DATA_NIBS + 1)) // R12
                                state_reg <= cfg.pause_en ? AST_PAUSE : AST_IDLE; // R15
                            else
                                nib_idx_reg <= nib_idx_reg + 3'h1;
                        end
                        else
                            seg_cnt_reg <= seg_cnt_reg + 6'h01;
                    end
                AST_PAUSE:
                    if (tick)
                    begin
                        if (seg_cnt_reg == AST_PAUSE_TICKS - 6'h01) // R15
                            state_reg <= AST_IDLE;
                        else
                            seg_cnt_reg <= seg_cnt_reg + 6'h01;
                    end
                default: state_reg <= AST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // line drive: every segment opens with five low ticks
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            line_out <= 1'b1;
        else if (prog_mode || state_reg == AST_IDLE) // R19
            line_out <= 1'b1;
        else
            line_out <= !(seg_cnt_reg < {1'b0, AST_LOW_TICKS}); // R7 R8
    end

    assign frame_busy = (state_reg != AST_IDLE);

    // ======================================================================
    // checks
    low_five_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == AST_NIB && seg_cnt_reg == 6'h02 && !prog_mode) |=> !line_out) // R8
        else $error("nibble low interval not low");
    high_after_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == AST_NIB && seg_cnt_reg == 6'h06 && !prog_mode) |=> line_out) // R9
        else $error("nibble high interval not high");
    prog_stop_a: assert property (@(posedge clk) disable iff (!resetn)
        prog_mode |=> state_reg == AST_IDLE ##1 line_out) // R19
        else $error("frame not abandoned in programming mode");
    trig_wait_a: assert property (@(posedge clk) disable iff (!resetn)
        (cfg.mode == AST_MODE_TRIG && state_reg == AST_IDLE && !trigger && !prog_mode)
        |=> state_reg == AST_IDLE) // R5
        else $error("triggered mode started unasked");
    sync_first_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == AST_IDLE && start && !prog_mode) |=> state_reg == AST_SYNC) // R12
        else $error("frame did not open with sync");
    tick_range_a: assert property (@(posedge clk) disable iff (!resetn)
        tick_len >= 11'(AST_TICK_MIN_CYC) && tick_len <= 11'(AST_TICK_MAX_CYC)) // R4
        else $error("tick out of range");
    angle_path_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == AST_IDLE && start && !prog_mode) |=> ang_reg == $past(diff[11:0])) // R16
        else $error("angle not offset corrected");
    sync_len_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == AST_SYNC && tick && seg_cnt_reg == 6'h37 && !prog_mode)
        |=> state_reg == AST_NIB) // R20
        else $error("sync pulse length wrong");

    // ======================================================================
    // low run length, in clock cycles
    logic [12:0] low_run_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            low_run_reg <= 13'h0000;
        else if (!line_out)
            low_run_reg <= low_run_reg + 13'h0001;
        else
            low_run_reg <= 13'h0000;
    end

    // ======================================================================
    // segment steps
    sequence nib_low_seq;
        state_reg == AST_NIB && seg_cnt_reg < {1'b0, AST_LOW_TICKS} && !prog_mode;
    endsequence

    sequence nib_high_seq;
        state_reg == AST_NIB && seg_cnt_reg >= {1'b0, AST_LOW_TICKS} && !prog_mode;
    endsequence

    sequence sync_low_seq;
        state_reg == AST_SYNC && seg_cnt_reg < {1'b0, AST_LOW_TICKS} && !prog_mode;
    endsequence

    sequence sync_high_seq;
        state_reg == AST_SYNC && seg_cnt_reg >= {1'b0, AST_LOW_TICKS} && !prog_mode;
    endsequence

    sequence crc_end_seq;
        state_reg == AST_NIB && tick && nib_idx_reg == 3'(AST_DATA_NIBS + 1)
        && seg_cnt_reg == nib_len - 6'h01 && !prog_mode;
    endsequence

    // ======================================================================
    // segment checks
    nib_low_a: assert property (@(posedge clk) disable iff (!resetn)
        nib_low_seq |=> !line_out) // R7
        else $error("nibble not low in delimiter");

    nib_high_a: assert property (@(posedge clk) disable iff (!resetn)
        nib_high_seq |=> line_out) // R9
        else $error("nibble not high in payload");

    sync_low_a: assert property (@(posedge clk) disable iff (!resetn)
        sync_low_seq |=> !line_out) // R20
        else $error("sync not low in delimiter");

    sync_high_a: assert property (@(posedge clk) disable iff (!resetn)
        sync_high_seq |=> line_out) // R20
        else $error("sync not high after delimiter");

    low_bound_a: assert property (@(posedge clk) disable iff (!resetn)
        !line_out |-> low_run_reg < 13'h0005 * {2'b00, tick_len}) // R8
        else $error("line low longer than five ticks");

    end_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        crc_end_seq ##0 !cfg.pause_en |=> state_reg == AST_IDLE) // R12
        else $error("frame did not end after crc");

    end_pause_a: assert property (@(posedge clk) disable iff (!resetn)
        crc_end_seq ##0 cfg.pause_en |=> state_reg == AST_PAUSE) // R15
        else $error("pause pulse missing after crc");

    idle_high_a: assert property (@(posedge clk) disable iff (!resetn)
        state_reg == AST_IDLE |=> line_out) // R7
        else $error("line not high while idle");

    trim_load_a: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_load && cfg_addr == AST_TRIM_ADDR) |=> trim_reg == $past(cfg_word[12:0])) // R17
        else $error("zero offset not captured");

    free_run_a: assert property (@(posedge clk) disable iff (!resetn)
        (cfg.mode == AST_MODE_FREE && state_reg == AST_IDLE && !prog_mode)
        |=> state_reg == AST_SYNC) // R3
        else $error("free mode did not restart");

    nib_count_a: assert property (@(posedge clk) disable iff (!resetn)
        nib_idx_reg <= 3'(AST_DATA_NIBS + 1)) // R12
        else $error("too many nibbles in frame");
endmodule
`default_nettype wire

/* File: sim/ast_host_rx.sv */
// host receiver model: measures falling-edge to falling-edge pulse lengths
// assumes line idles high and busy falls when a frame is complete
`timescale 1ns/100ps
`default_nettype none
module ast_host_rx
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic line,
    input wire logic busy
);
    // ==========================================================
    // pulse capture, in clock cycles
    int   cnt;
    logic line_d;
    logic busy_d;
    logic armed;
    int   per_q[$];
    int   low_q[$];
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt = 0;
            armed = 1'b0;
            line_d = 1'b1;
            busy_d = 1'b0;
        end
        else
        begin
            cnt++;
            if (line_d && !line)
            begin
                if (armed)
                    per_q.push_back(cnt);
                cnt = 0;
                armed = 1'b1;
            end
            else if (!line_d && line)
                low_q.push_back(cnt);
            if (busy_d && !busy && armed)
            begin
                // busy leads the registered line by one cycle
                per_q.push_back(cnt + 1);
                armed = 1'b0;
            end
            line_d = line;
            busy_d = busy;
        end
    end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// testbench for the nibble angle transmitter
// assumes the host model decodes pulse lengths from the line
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ast_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    ast_cfg_s    cfg = '{AST_MODE_TRIG, 11'h064, 1'b0, 1'b1, 4'h0};
    logic [11:0] cfg_addr = 12'h000;
    logic [15:0] cfg_word = 16'h0000;
    logic        cfg_load = 1'b0;
    logic [12:0] lin_angle = 13'h0000;
    logic [1:0]  status_bits = 2'h2;
    logic        serial_bit = 1'b1;
    logic        trigger = 1'b0;
    logic        addr_hit = 1'b0;
    logic        poll_turn = 1'b0;
    logic        prog_mode = 1'b0;
    logic        line_out;
    logic        frame_busy;
    logic [11:0] angle_out;
    logic [12:0] la;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;
    always #2.5 clk = ~clk;
    ast_sent_tx ast_sent_tx_i (.clk(clk), .resetn(resetn), .cfg(cfg), .cfg_addr(cfg_addr),
        .cfg_word(cfg_word), .cfg_load(cfg_load), .lin_angle(lin_angle),
        .status_bits(status_bits), .serial_bit(serial_bit), .trigger(trigger),
        .addr_hit(addr_hit), .poll_turn(poll_turn), .prog_mode(prog_mode),
        .line_out(line_out), .frame_busy(frame_busy), .angle_out(angle_out));
    ast_host_rx ast_host_rx_i (.clk(clk), .resetn(resetn), .line(line_out), .busy(frame_busy));
    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [3:0] crc_calc(input logic [3:0] s, input logic [11:0] a);
        logic [3:0]  c;
        logic [19:0] m;
        logic        fb;
        c = 4'h5;
        m = {s, a, 4'h0};
        for (int i = 19; i >= 0; i--)
        begin
            fb = c[3];
            c = {c[2:0], m[i]};
            if (fb)
                c = c ^ 4'hd;
        end
        return c;
    endfunction
    task automatic frame(input logic [11:0] a, input logic [3:0] st, input bit pz, input int t);
        int e[7];
        int n;
        e = '{56, 12 + st, 12 + a[11:8], 12 + a[7:4], 12 + a[3:0], 12 + crc_calc(st, a), 12};
        n = pz ? 7 : 6;
        for (int i = 0; i < 25000 && ast_host_rx_i.per_q.size() < n; i++)
            @(posedge clk);
        check(32'(ast_host_rx_i.per_q.size() >= n), 32'h1);
        for (int k = 0; k < n && k < ast_host_rx_i.per_q.size(); k++)
        begin
            check(ast_host_rx_i.per_q[k], e[k] * t);
            check(ast_host_rx_i.low_q[k], 5 * t);
        end
        check(angle_out, a);
        for (int i = 0; i < 25000 && frame_busy !== 1'b0 && cfg.mode != AST_MODE_FREE; i++)
            @(posedge clk);
        ast_host_rx_i.per_q.delete();
        ast_host_rx_i.low_q.delete();
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            err_count++;
            final_report();
        end
    end
    // ==========================================================
    // scenarios
    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check({line_out, frame_busy, angle_out}, 32'h2000);
        @(posedge clk);
        cfg_addr <= AST_TRIM_ADDR;
        cfg_word <= 16'he123;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_addr <= 12'h305;
        cfg_word <= 16'hffff;
        @(posedge clk);
        cfg_load <= 1'b0;
        repeat (50) @(posedge clk);
        check(frame_busy, 1'b0);
        for (int m = 1; m < 4; m++)
        begin
            la = 13'h0100 + 13'(m) * 13'h0f11;
            cfg.mode <= ast_mode_e'(m);
            cfg.tick_cyc <= 11'h064 + 11'(m);
            cfg.serial_en <= (m == 1);
            lin_angle <= la;
            @(posedge clk);
            trigger <= (m == 1);
            addr_hit <= (m == 2);
            poll_turn <= (m == 3);
            @(posedge clk);
            {trigger, addr_hit, poll_turn} <= 3'h0;
            frame(12'(la - 13'h0123), {m == 1, 3'h2}, 1'b0, 100 + m);
        end
        cfg.mode <= AST_MODE_TRIG;
        trigger <= 1'b1;
        @(posedge clk);
        trigger <= 1'b0;
        repeat (100) @(posedge clk);
        prog_mode <= 1'b1;
        repeat (2) @(negedge clk);
        check({line_out, frame_busy}, 2'h2);
        @(posedge clk);
        prog_mode <= 1'b0;
        @(posedge clk);
        ast_host_rx_i.per_q.delete();
        ast_host_rx_i.low_q.delete();
        lin_angle <= 13'h1122;
        cfg.serial_en <= 1'b0;
        cfg.pause_en <= 1'b1;
        cfg.tick_cyc <= 11'h064;
        cfg.mode <= AST_MODE_FREE;
        frame(12'hfff, 4'h2, 1'b1, 100);
        final_report();
    end
endmodule
`default_nettype wire
